// >>> design/mdd_decoder.sv
// Destination decoder of the register-to-register move instruction.
// Assumes the fetch stage presents one instruction per handshake on the core clock.
module mdd_decoder (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [mdd_pkg::MDD_CODE_W-1:0] dst_code,
  input wire logic [15:0] src_data,
  input wire logic src_word,
  input wire logic mem_word,
  output logic instr_ready,
  output logic done,
  output logic write_en,
  output logic illegal,
  output logic [mdd_pkg::MDD_CLS_W-1:0] target_class,
  output logic [3:0] target_index,
  output logic [2:0] target_group,
  output logic target_word,
  output logic [1:0] ptr_op,
  output logic [15:0] write_data,
  output logic bank_two
);
  import mdd_pkg::*;

  typedef struct packed {
    mdd_state_t st;
    logic [7:0][7:0] pfx;
    logic pend;
    logic [2:0] pend_idx;
    logic ready;
    logic done;
    logic write;
    logic illegal;
    logic [4:0] cls;
    logic [3:0] idx;
    logic [2:0] grp;
    logic word;
    logic [1:0] ptr;
    logic [15:0] data;
    logic bank2;
  } mdd_regs_t;

  mdd_regs_t r_q;
  mdd_regs_t r_d;

  // Builds one decode result; keeps the case arms short.
  function automatic mdd_dec_t mk(input logic [4:0] cls, input logic [3:0] idx,
                                  input logic is_word, input logic [1:0] ptr);
    mdd_dec_t m;
    m.cls = cls;
    m.idx = idx;
    m.grp = 3'h0;
    m.is_word = is_word;
    m.var_width = 1'b0;
    m.ptr = ptr;
    m.two_cycle = 1'b0;
    return m;
  endfunction : mk

  // System register group of the first bank, selected by the upper code bits.
  function automatic mdd_dec_t sys_first(input logic [2:0] hi);
    mdd_dec_t m;
    case (hi)
      3'h0: m = mk(MDD_T_ACC_PTR, 4'h0, 1'b0, MDD_PTR_NONE);
      3'h1: m = mk(MDD_T_ACC_PTR_CTRL, 4'h0, 1'b0, MDD_PTR_NONE);
      3'h4: m = mk(MDD_T_STATUS, 4'h0, 1'b0, MDD_PTR_NONE);
      3'h5: m = mk(MDD_T_INT_CTRL, 4'h0, 1'b0, MDD_PTR_NONE);
      3'h6: m = mk(MDD_T_INT_MASK, 4'h0, 1'b0, MDD_PTR_NONE);
      default: m = mk(MDD_T_INVALID, 4'h0, 1'b0, MDD_PTR_NONE);
    endcase
    return m;
  endfunction : sys_first

  // Slow control registers of the second bank; each one needs a second cycle.
  function automatic mdd_dec_t sys_second(input logic [2:0] hi);
    mdd_dec_t m;
    case (hi)
      3'h0: m = mk(MDD_T_SYS_CTRL, 4'h0, 1'b0, MDD_PTR_NONE);
      3'h6: m = mk(MDD_T_CLK_CTRL, 4'h0, 1'b0, MDD_PTR_NONE);
      3'h7: m = mk(MDD_T_WDOG_CTRL, 4'h0, 1'b0, MDD_PTR_NONE);
      default: m = mk(MDD_T_INVALID, 4'h0, 1'b0, MDD_PTR_NONE);
    endcase
    m.two_cycle = (m.cls != MDD_T_INVALID);
    return m;
  endfunction : sys_second

  // Width the target takes: fixed for registers, the access width for memory and
  // module targets, and the source width for the discard target.
  function automatic logic word_target(input mdd_dec_t m, input logic sw, input logic mw);
    logic w;
    if (!m.var_width) begin
      w = m.is_word;
    end else if (m.cls == MDD_T_DISCARD) begin
      w = sw;
    end else begin
      w = mw;
    end
    return w;
  endfunction : word_target

  // A result writes a register unless it is the discard target or undefined.
  function automatic logic commits(input logic [4:0] cls);
    return (cls != MDD_T_DISCARD) && (cls != MDD_T_INVALID);
  endfunction : commits

  // First-bank decode of the seven-bit destination field.
  function automatic mdd_dec_t dec_first(input logic [6:0] code);
    mdd_dec_t m;
    logic [2:0] hi;
    logic [3:0] lo;
    hi = code[6:4];
    lo = code[3:0];
    // Anything not matched below stays invalid and raises the illegal flag.
    m = mk(MDD_T_INVALID, 4'h0, 1'b0, MDD_PTR_NONE);
    if (code == MDD_DISCARD_CODE) begin
      m = mk(MDD_T_DISCARD, 4'h0, 1'b0, MDD_PTR_NONE);
      m.var_width = 1'b1;
    end else if (!lo[3]) begin
      if (lo[2:0] <= MDD_LAST_MODULE) begin
        m = mk(MDD_T_MODULE, {1'b0, hi}, 1'b0, MDD_PTR_NONE);
        m.grp = lo[2:0];
        m.var_width = 1'b1;
      end
    end else begin
      case (lo)
        MDD_LO_SYS: begin
          m = sys_first(hi);
        end
        MDD_LO_ACC: begin
          m = mk(MDD_T_ACC, {1'b0, hi}, 1'b1, MDD_PTR_NONE);
        end
        MDD_LO_ACT: begin
          if (hi == 3'h0) begin
            m = mk(MDD_T_ACTIVE_ACC, 4'h0, 1'b1, MDD_PTR_NONE);
          end
        end
        MDD_LO_PREFIX: begin
          m = mk(MDD_T_PREFIX, {1'b0, hi}, 1'b0, MDD_PTR_NONE);
        end
        MDD_LO_STK: begin
          case (hi)
            3'h0: m = mk(MDD_T_STACK_PUSH, 4'h0, 1'b1, MDD_PTR_INC);
            3'h1: m = mk(MDD_T_STACK_PTR, 4'h0, 1'b1, MDD_PTR_NONE);
            3'h2: m = mk(MDD_T_INT_VECTOR, 4'h0, 1'b1, MDD_PTR_NONE);
            3'h6, 3'h7: m = mk(MDD_T_LOOP, {3'h0, hi[0]}, 1'b1, MDD_PTR_NONE);
            default: m = mk(MDD_T_INVALID, 4'h0, 1'b0, MDD_PTR_NONE);
          endcase
        end
        MDD_LO_FRM: begin
          case (hi)
            3'h0: m = mk(MDD_T_FRAME_MEM, 4'h0, 1'b0, MDD_PTR_NONE);
            3'h1: m = mk(MDD_T_FRAME_MEM, 4'h0, 1'b0, MDD_PTR_INC);
            3'h2: m = mk(MDD_T_FRAME_MEM, 4'h0, 1'b0, MDD_PTR_DEC);
            3'h3: m = mk(MDD_T_FRAME_DISP, 4'h0, 1'b0, MDD_PTR_NONE);
            3'h4: m = mk(MDD_T_PTR_CTRL, 4'h0, 1'b1, MDD_PTR_NONE);
            3'h5: m = mk(MDD_T_GENERAL, 4'h0, 1'b1, MDD_PTR_NONE);
            3'h6: m = mk(MDD_T_GENERAL_LO, 4'h0, 1'b0, MDD_PTR_NONE);
            default: m = mk(MDD_T_FRAME_BASE, 4'h0, 1'b1, MDD_PTR_NONE);
          endcase
          m.var_width = (m.cls == MDD_T_FRAME_MEM);
        end
        MDD_LO_DPT: begin
          case (hi[1:0])
            2'h0: m = mk(MDD_T_PTR_MEM, {3'h0, hi[2]}, 1'b0, MDD_PTR_NONE);
            2'h1: m = mk(MDD_T_PTR_MEM, {3'h0, hi[2]}, 1'b0, MDD_PTR_INC);
            2'h2: m = mk(MDD_T_PTR_MEM, {3'h0, hi[2]}, 1'b0, MDD_PTR_DEC);
            default: m = mk(MDD_T_DATA_PTR, {3'h0, hi[2]}, 1'b1, MDD_PTR_NONE);
          endcase
          m.var_width = (m.cls == MDD_T_PTR_MEM);
        end
        default: m = mk(MDD_T_INVALID, 4'h0, 1'b0, MDD_PTR_NONE);
      endcase
    end
    return m;
  endfunction : dec_first

  // Second-bank decode; codes the second bank does not redefine keep their first meaning.
  function automatic mdd_dec_t dec_second(input logic [6:0] code);
    mdd_dec_t m;
    logic [2:0] hi;
    logic [3:0] lo;
    hi = code[6:4];
    lo = code[3:0];
    m = dec_first(code);
    if (lo == MDD_LO_SYS) begin
      m = sys_second(hi);
    end else if (lo == MDD_LO_ACC) begin
      m = mk(MDD_T_ACC, {1'b1, hi}, 1'b1, MDD_PTR_NONE);
    end else if (lo == MDD_LO_FRM && hi == 3'h1) begin
      m = mk(MDD_T_GENERAL_HI, 4'h0, 1'b0, MDD_PTR_NONE);
    end else if (!lo[3] && (m.cls == MDD_T_MODULE)) begin
      // The prefix opens the upper registers of each peripheral module.
      m.idx = {1'b1, hi};
    end
    return m;
  endfunction : dec_second

  mdd_dec_t dec;
  logic use_bank2;
  logic take;
  logic dst_word;
  logic hi_valid;
  logic [15:0] conv_data;

  // Only a prefix loaded by the instruction just before can open the second bank.
  assign use_bank2 = r_q.pend && r_q.pend_idx[MDD_BANK_BIT];
  assign take = instr_valid && r_q.ready;
  assign dec = use_bank2 ? dec_second(dst_code) : dec_first(dst_code);
  assign dst_word = word_target(dec, src_word, mem_word);
  assign hi_valid = r_q.pend && (r_q.pend_idx == MDD_HI_PREFIX);

  // Conversion works on the live source so the result lands together with the decode.
  mdd_width_conv u_conv (
    .src_data(src_data),
    .src_word(src_word),
    .dst_word(dst_word),
    .hi_valid(hi_valid),
    .hi_byte(r_q.pfx[MDD_HI_PREFIX]),
    .dst_data(conv_data)
  );

  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.write = 1'b0;
    case (r_q.st)
      MDD_ST_IDLE: begin
        if (take) begin
          r_d.cls = dec.cls;
          r_d.idx = dec.idx;
          r_d.grp = dec.grp;
          r_d.word = dst_word;
          r_d.ptr = dec.ptr;
          r_d.data = conv_data;
          r_d.bank2 = use_bank2;
          r_d.illegal = (dec.cls == MDD_T_INVALID);
          // The prefix is consumed by this instruction whatever it does.
          r_d.pend = 1'b0;
          if (dec.cls == MDD_T_PREFIX) begin
            r_d.pfx[dec.idx[2:0]] = src_data[7:0];
            r_d.pend = 1'b1;
            r_d.pend_idx = dec.idx[2:0];
          end
          if (dec.two_cycle) begin
            // Slow control registers need a second cycle; no new instruction meanwhile.
            r_d.st = MDD_ST_HOLD;
            r_d.ready = 1'b0;
          end else begin
            r_d.done = 1'b1;
            r_d.write = commits(dec.cls);
          end
        end
      end
      MDD_ST_HOLD: begin
        // The decoded fields stand from the take; only the strobes and ready rise here.
        r_d.st = MDD_ST_IDLE;
        r_d.ready = 1'b1;
        r_d.done = 1'b1;
        r_d.write = commits(r_q.cls);
      end
      default: begin
        r_d.st = MDD_ST_IDLE;
        r_d.ready = 1'b1;
      end
    endcase
  end

  // Reset clears the prefix bank too, so no stale high byte survives a restart.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r_q.st <= MDD_ST_IDLE;
      r_q.pfx <= '0;
      r_q.pend <= 1'b0;
      r_q.pend_idx <= 3'h0;
      r_q.ready <= 1'b1;
      r_q.done <= 1'b0;
      r_q.write <= 1'b0;
      r_q.illegal <= 1'b0;
      r_q.cls <= MDD_T_NONE;
      r_q.idx <= 4'h0;
      r_q.grp <= 3'h0;
      r_q.word <= 1'b0;
      r_q.ptr <= MDD_PTR_NONE;
      r_q.data <= 16'h0000;
      r_q.bank2 <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // Every output is a register field, so the consumer never sees decode glitches.
  assign instr_ready = r_q.ready;
  assign done = r_q.done;
  assign write_en = r_q.write;
  assign illegal = r_q.illegal;
  assign target_class = r_q.cls;
  assign target_index = r_q.idx;
  assign target_group = r_q.grp;
  assign target_word = r_q.word;
  assign ptr_op = r_q.ptr;
  assign write_data = r_q.data;
  assign bank_two = r_q.bank2;

endmodule : mdd_decoder

// >>> design/mdd_pkg.sv
// Constants, codes and types for the move destination decoder.
// Assumes one core clock and a synchronous active-low reset in every user.
package mdd_pkg;

  localparam int MDD_CODE_W = 7;
  localparam int MDD_CLS_W = 5;

  // Low-nibble group codes of the destination field.
  localparam logic [3:0] MDD_LO_SYS = 4'h8;
  localparam logic [3:0] MDD_LO_ACC = 4'h9;
  localparam logic [3:0] MDD_LO_ACT = 4'hA;
  localparam logic [3:0] MDD_LO_PREFIX = 4'hB;
  localparam logic [3:0] MDD_LO_STK = 4'hD;
  localparam logic [3:0] MDD_LO_FRM = 4'hE;
  localparam logic [3:0] MDD_LO_DPT = 4'hF;
  localparam logic [2:0] MDD_LAST_MODULE = 3'h5;
  localparam logic [6:0] MDD_DISCARD_CODE = 7'h76;

  // Prefix register index bit that turns on the second destination bank.
  localparam int MDD_BANK_BIT = 1;
  // Prefix register whose value feeds the high byte of byte-to-word moves.
  localparam logic [2:0] MDD_HI_PREFIX = 3'h0;
  localparam logic [7:0] MDD_PAD_BYTE = 8'h00;

  // Pointer side effects reported with a memory target.
  localparam logic [1:0] MDD_PTR_NONE = 2'h0;
  localparam logic [1:0] MDD_PTR_INC = 2'h1;
  localparam logic [1:0] MDD_PTR_DEC = 2'h2;

  // Target classes.
  localparam logic [4:0] MDD_T_NONE = 5'h00;
  localparam logic [4:0] MDD_T_DISCARD = 5'h01;
  localparam logic [4:0] MDD_T_MODULE = 5'h02;
  localparam logic [4:0] MDD_T_ACC_PTR = 5'h03;
  localparam logic [4:0] MDD_T_ACC_PTR_CTRL = 5'h04;
  localparam logic [4:0] MDD_T_STATUS = 5'h05;
  localparam logic [4:0] MDD_T_INT_CTRL = 5'h06;
  localparam logic [4:0] MDD_T_INT_MASK = 5'h07;
  localparam logic [4:0] MDD_T_ACC = 5'h08;
  localparam logic [4:0] MDD_T_ACTIVE_ACC = 5'h09;
  localparam logic [4:0] MDD_T_PREFIX = 5'h0A;
  localparam logic [4:0] MDD_T_STACK_PUSH = 5'h0B;
  localparam logic [4:0] MDD_T_STACK_PTR = 5'h0C;
  localparam logic [4:0] MDD_T_INT_VECTOR = 5'h0D;
  localparam logic [4:0] MDD_T_LOOP = 5'h0E;
  localparam logic [4:0] MDD_T_FRAME_MEM = 5'h0F;
  localparam logic [4:0] MDD_T_FRAME_DISP = 5'h10;
  localparam logic [4:0] MDD_T_PTR_CTRL = 5'h11;
  localparam logic [4:0] MDD_T_GENERAL = 5'h12;
  localparam logic [4:0] MDD_T_GENERAL_LO = 5'h13;
  localparam logic [4:0] MDD_T_GENERAL_HI = 5'h14;
  localparam logic [4:0] MDD_T_FRAME_BASE = 5'h15;
  localparam logic [4:0] MDD_T_PTR_MEM = 5'h16;
  localparam logic [4:0] MDD_T_DATA_PTR = 5'h17;
  localparam logic [4:0] MDD_T_SYS_CTRL = 5'h18;
  localparam logic [4:0] MDD_T_CLK_CTRL = 5'h19;
  localparam logic [4:0] MDD_T_WDOG_CTRL = 5'h1A;
  localparam logic [4:0] MDD_T_INVALID = 5'h1F;

  typedef enum logic [1:0] {
    MDD_ST_IDLE = 2'b01,
    MDD_ST_HOLD = 2'b10
  } mdd_state_t;

  typedef struct packed {
    logic [4:0] cls;
    logic [3:0] idx;
    logic [2:0] grp;
    logic is_word;
    logic var_width;
    logic [1:0] ptr;
    logic two_cycle;
  } mdd_dec_t;

endpackage : mdd_pkg

// >>> design/mdd_width_conv.sv
// Width conversion between the move source and the decoded target.
// Assumes the caller registers the result; this module is purely combinational.
module mdd_width_conv (
  input wire logic [15:0] src_data,
  input wire logic src_word,
  input wire logic dst_word,
  input wire logic hi_valid,
  input wire logic [7:0] hi_byte,
  output logic [15:0] dst_data
);
  import mdd_pkg::*;

  always_comb begin
    if (!dst_word) begin
      dst_data = {MDD_PAD_BYTE, src_data[7:0]};
    end else if (src_word) begin
      dst_data = src_data;
    end else if (hi_valid) begin
      dst_data = {hi_byte, src_data[7:0]};
    end else begin
      dst_data = {MDD_PAD_BYTE, src_data[7:0]};
    end
  end

endmodule : mdd_width_conv

// >>> verification/mdd_decoder_assertions.sv
// Port-level checks on the move destination decoder.
// Assumes one core clock and a synchronous active-low reset; bound to mdd_decoder.
module mdd_decoder_assertions
  import mdd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [mdd_pkg::MDD_CODE_W-1:0] dst_code,
  input wire logic [15:0] src_data,
  input wire logic src_word,
  input wire logic instr_ready,
  input wire logic done,
  input wire logic write_en,
  input wire logic [mdd_pkg::MDD_CLS_W-1:0] target_class,
  input wire logic [3:0] target_index,
  input wire logic [2:0] target_group,
  input wire logic [1:0] ptr_op,
  input wire logic [15:0] write_data,
  input wire logic bank_two
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic [6:0] code_q;
  logic [15:0] data_q;
  assign take = instr_valid && instr_ready;
  always_ff @(posedge mclk) begin
    code_q <= dst_code;
    data_q <= src_data;
  end
  a_discard_quiet: assert property (take && dst_code == MDD_DISCARD_CODE |=>
    done && target_class == MDD_T_DISCARD && !write_en) else $error("discard wrote");
  a_module_map: assert property (take && !dst_code[3] &&
    dst_code[2:0] <= MDD_LAST_MODULE |=> target_class == MDD_T_MODULE &&
    target_group == code_q[2:0] && target_index == {bank_two, code_q[6:4]})
    else $error("module map");
  a_acc_index: assert property (take && dst_code[3:0] == MDD_LO_ACC |=>
    target_class == MDD_T_ACC && target_index == {bank_two, code_q[6:4]}) else $error("acc index");
  a_prefix_load: assert property (take && dst_code[3:0] == MDD_LO_PREFIX |=>
    target_class == MDD_T_PREFIX && write_en && target_index[2:0] == code_q[6:4])
    else $error("prefix load");
  a_push_incr: assert property (take && dst_code == 7'h0D |=>
    target_class == MDD_T_STACK_PUSH && ptr_op == MDD_PTR_INC) else $error("push op");
  a_two_cycle_gap: assert property (!instr_ready |-> !done ##1 (done && instr_ready))
    else $error("two cycle gap");
  a_word_copy: assert property (take && src_word && dst_code == 7'h5E |=>
    write_data == data_q) else $error("word copy");
  a_byte_trunc: assert property (take && dst_code == 7'h6E |=>
    target_class == MDD_T_GENERAL_LO && write_data == {8'h00, data_q[7:0]})
    else $error("byte trunc");
  a_pointer_select: assert property (take && dst_code[3:0] == MDD_LO_DPT |=>
    target_index[0] == code_q[6]) else $error("pointer select");
endmodule : mdd_decoder_assertions

bind mdd_decoder mdd_decoder_assertions u_chk (.mclk, .rst_n, .instr_valid, .dst_code,
  .src_data, .src_word, .instr_ready, .done, .write_en, .target_class, .target_index,
  .target_group, .ptr_op, .write_data, .bank_two);

// >>> verification/testbench.sv
// Self-checking bench for the move destination decoder.
// Assumes a 100 MHz core clock; the bench drives every port itself.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [6:0] code;
    logic [4:0] cls;
    logic [3:0] idx;
    logic [1:0] ptr;
    logic w;
  } mdd_row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [6:0] dst_code = 7'h00;
  logic [15:0] src_data = 16'h0000;
  logic src_word = 1'b0;
  logic mem_word = 1'b1;
  logic instr_ready, done, write_en, illegal, target_word, bank_two;
  logic [4:0] target_class;
  logic [3:0] target_index;
  logic [2:0] target_group;
  logic [1:0] ptr_op;
  logic [15:0] write_data;
  int fails = 0;
  int comparisons = 0;
  int n;
  logic rdy;
  logic [6:0] two [3] = '{7'h08, 7'h68, 7'h78};
  logic [6:0] pf [3] = '{7'h2B, 7'h3B, 7'h7B};
  // Index 4'hF means the index is not compared for that row.
  mdd_row_t rows [26] = '{'{7'h76,5'h01,4'hF,2'h0,1'b1}, '{7'h35,5'h02,4'h3,2'h0,1'b1},
    '{7'h06,5'h1F,4'hF,2'h0,1'b0}, '{7'h08,5'h03,4'hF,2'h0,1'b0},
    '{7'h18,5'h04,4'hF,2'h0,1'b0}, '{7'h48,5'h05,4'hF,2'h0,1'b0},
    '{7'h58,5'h06,4'hF,2'h0,1'b0}, '{7'h68,5'h07,4'hF,2'h0,1'b0},
    '{7'h78,5'h1F,4'hF,2'h0,1'b0}, '{7'h79,5'h08,4'h7,2'h0,1'b1},
    '{7'h0A,5'h09,4'hF,2'h0,1'b1}, '{7'h0D,5'h0B,4'hF,2'h1,1'b1},
    '{7'h1D,5'h0C,4'hF,2'h0,1'b1}, '{7'h2D,5'h0D,4'hF,2'h0,1'b1},
    '{7'h7D,5'h0E,4'h1,2'h0,1'b1}, '{7'h1E,5'h0F,4'hF,2'h1,1'b1},
    '{7'h2E,5'h0F,4'hF,2'h2,1'b1}, '{7'h3E,5'h10,4'hF,2'h0,1'b0},
    '{7'h4E,5'h11,4'hF,2'h0,1'b1}, '{7'h5E,5'h12,4'hF,2'h0,1'b1},
    '{7'h6E,5'h13,4'hF,2'h0,1'b0}, '{7'h7E,5'h15,4'hF,2'h0,1'b1},
    '{7'h0F,5'h16,4'h0,2'h0,1'b1}, '{7'h5F,5'h16,4'h1,2'h1,1'b1},
    '{7'h6F,5'h16,4'h1,2'h2,1'b1}, '{7'h7F,5'h17,4'h1,2'h0,1'b1}};

  mdd_decoder dut (.mclk, .rst_n, .instr_valid, .dst_code, .src_data, .src_word, .mem_word,
    .instr_ready, .done, .write_en, .illegal, .target_class, .target_index, .target_group,
    .target_word, .ptr_op, .write_data, .bank_two);

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Waits for done under a bound; n counts edges past the take, rdy is ready just after it.
  task automatic issue(input logic [6:0] c, input logic [15:0] d, input logic sw,
                       output int k, output logic r);
    @(posedge mclk);
    instr_valid <= 1'b1;
    dst_code <= c;
    src_data <= d;
    src_word <= sw;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    k = 0;
    r = instr_ready;
    while (done !== 1'b1 && k < 8) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask : issue

  task automatic do_reset(input int k);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (k) @(posedge mclk);
    #1;
    chk("rst_ready", 16'(instr_ready), 16'h0001);
    chk("rst_class", 16'(target_class), 16'h0000);
    chk("rst_flags", 16'(done | write_en | illegal), 16'h0000);
    @(posedge mclk);
    rst_n <= 1'b1;
  endtask : do_reset

  initial begin
    repeat (2000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  initial begin
    do_reset(8);
    foreach (rows[i]) begin
      issue(rows[i].code, 16'hA5C3, 1'b1, n, rdy);
      chk("latency", 16'(n), 16'h0000);
      chk("class", 16'(target_class), 16'(rows[i].cls));
      chk("illegal", 16'(illegal), 16'(rows[i].cls == 5'h1F));
      chk("write", 16'(write_en), 16'(rows[i].cls != 5'h1F && rows[i].cls != 5'h01));
      chk("group", 16'(target_group),
        rows[i].cls == 5'h02 ? 16'(rows[i].code[2:0]) : 16'h0);
      if (rows[i].cls != 5'h1F) begin
        chk("ptr", 16'(ptr_op), 16'(rows[i].ptr));
        chk("word", 16'(target_word), 16'(rows[i].w));
        chk("data", write_data, rows[i].w ? 16'hA5C3 : 16'h00C3);
        if (rows[i].idx != 4'hF) chk("index", 16'(target_index), 16'(rows[i].idx));
      end
    end
    issue(7'h0B, 16'h005A, 1'b0, n, rdy);
    chk("pfx_class", 16'(target_class), 16'h000A);
    issue(7'h79, 16'h00C3, 1'b0, n, rdy);
    chk("hi_byte", write_data, 16'h5AC3);
    issue(7'h79, 16'h00C3, 1'b0, n, rdy);
    chk("pad_byte", write_data, 16'h00C3);
    foreach (two[i]) begin
      issue(pf[i], 16'h0000, 1'b1, n, rdy);
      issue(two[i], 16'hA5C3, 1'b1, n, rdy);
      chk("class2", 16'(target_class), 16'(5'h18 + 5'(i)));
      chk("wait2", 16'(n), 16'h0001);
      chk("refuse2", 16'(rdy), 16'h0000);
      chk("data2", write_data, 16'h00C3);
    end
    issue(7'h6B, 16'h0000, 1'b1, n, rdy);
    issue(7'h39, 16'hA5C3, 1'b1, n, rdy);
    chk("acc_hi", 16'({bank_two, target_index}), 16'h001B);
    issue(7'h39, 16'hA5C3, 1'b1, n, rdy);
    chk("acc_lo", 16'({bank_two, target_index}), 16'h0003);
    issue(7'h3B, 16'h0000, 1'b1, n, rdy);
    issue(7'h1E, 16'hA5C3, 1'b1, n, rdy);
    chk("gen_hi", 16'(target_class), 16'h0014);
    issue(7'h2B, 16'h0000, 1'b1, n, rdy);
    @(posedge mclk);
    mem_word <= 1'b0;
    issue(7'h35, 16'hA5C3, 1'b1, n, rdy);
    chk("mod_hi", 16'({bank_two, target_index}), 16'h001B);
    chk("mod_word", 16'(target_word), 16'h0000);
    chk("mod_data", write_data, 16'h00C3);
    issue(7'h0E, 16'hA5C3, 1'b1, n, rdy);
    chk("frame_cls", 16'({target_class, ptr_op}), 16'h003C);
    chk("frame_word", 16'(target_word), 16'h0000);
    chk("frame_data", write_data, 16'h00C3);
    @(posedge mclk);
    mem_word <= 1'b1;
    issue(7'h1B, 16'h0000, 1'b1, n, rdy);
    issue(7'h68, 16'hA5C3, 1'b1, n, rdy);
    chk("bank_one", 16'(target_class), 16'h0007);
    issue(7'h2B, 16'h0000, 1'b1, n, rdy);
    do_reset(1);
    issue(7'h68, 16'hA5C3, 1'b1, n, rdy);
    chk("after_rst", 16'(target_class), 16'h0007);
    wrap_up();
  end
endmodule : testbench
